// [core/tas_pkg.sv]
// Behaviour
// - no tariff code: tariff accumulators untouched
// - power bands: main only, then two
// - power upper bands select three, four
// - flow bands: main only, then two
// - flow upper bands select three, four
// - third limit zero disables accumulator four
// - limits read under selected code only
// - time mode: limits are band start times
// - volume mode splits heat and cooling volume
// - combined mode: power to two, flow three
// - main register takes every increment
// - evaluate and add at each integration
// - temperature difference bands descend
// - inlet temperature ascending bands
package tas_pkg;
  // ------------------------------------------------------------
  // widths and codes
  // ------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int INC_W = 16;
  localparam int ACC_W = 32;
  localparam logic [7:0] CODE_NONE   = 8'h00;
  localparam logic [7:0] CODE_POWER  = 8'h11;
  localparam logic [7:0] CODE_FLOW   = 8'h12;
  localparam logic [7:0] CODE_DT     = 8'h13;
  localparam logic [7:0] CODE_INLET  = 8'h14;
  localparam logic [7:0] CODE_OUTLET = 8'h15;
  localparam logic [7:0] CODE_TIME   = 8'h19;
  localparam logic [7:0] CODE_VOLUME = 8'h20;
  localparam logic [7:0] CODE_PQ     = 8'h21;
  localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [VAL_W-1:0] LIMIT_OFF = 16'h0000;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [VAL_W-1:0] first;
    logic [VAL_W-1:0] second;
    logic [VAL_W-1:0] third;
  } tas_limits_type;

  typedef struct packed {
    logic signed [VAL_W-1:0] power;
    logic signed [VAL_W-1:0] flow;
    logic signed [VAL_W-1:0] inlet;
    logic signed [VAL_W-1:0] outlet;
    logic signed [VAL_W-1:0] delta;
    logic        [VAL_W-1:0] time_of_day;
  } tas_meas_type;

  typedef struct packed {
    logic two;
    logic three;
    logic four;
  } tas_sel_type;
endpackage : tas_pkg

// [core/tas_selector.sv]
`timescale 1ns/100ps
module tas_selector
  import tas_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic [7:0]            tariff_type_code,
  input  wire tas_limits_type        limits,
  input  wire tas_meas_type          meas,
  input  wire logic signed [VAL_W-1:0] heat_cool_switch_threshold,
  input  wire logic                  incr_valid,
  input  wire logic [INC_W-1:0]      incr,
  output logic [ACC_W-1:0]           main_register,
  output logic [ACC_W-1:0]           tariff_accumulator_two,
  output logic [ACC_W-1:0]           tariff_accumulator_three,
  output logic [ACC_W-1:0]           tariff_accumulator_four
);
  // ------------------------------------------------------------
  // band decision
  // ------------------------------------------------------------
  tas_sel_type sel;
  logic signed [VAL_W-1:0] l1;
  logic signed [VAL_W-1:0] l2;
  logic signed [VAL_W-1:0] l3;
  logic                    four_on;

  assign l1 = limits.first;
  assign l2 = limits.second;
  assign l3 = limits.third;
  assign four_on = (limits.third != LIMIT_OFF);

  // ascending bands; with four off the top band stays in three
  // limits come in as arguments so the caller sees every one of them
  function automatic tas_sel_type up_band(input logic signed [VAL_W-1:0] v,
                                          input logic signed [VAL_W-1:0] b1,
                                          input logic signed [VAL_W-1:0] b2,
                                          input logic signed [VAL_W-1:0] b3,
                                          input logic en4);
    tas_sel_type s;
    s = '0;
    if (en4 && v > b3) begin
      s.four = 1'b1;
    end else if (v > b2) begin
      s.three = 1'b1;
    end else if (v > b1) begin
      s.two = 1'b1;
    end
    return s;
  endfunction : up_band

  always_comb begin
    sel = '0;
    case (tariff_type_code)
      CODE_NONE: sel = '0;
      CODE_POWER: sel = up_band(meas.power, l1, l2, l3,
                                four_on);
      CODE_FLOW: sel = up_band(meas.flow, l1, l2, l3,
                               four_on);
      CODE_INLET: sel = up_band(meas.inlet, l1, l2, l3,
                                four_on);
      CODE_OUTLET: sel = up_band(meas.outlet, l1, l2, l3,
                                 four_on);
      CODE_DT: begin
        if (four_on && meas.delta < l3) begin
          sel.four = 1'b1;
        end else if (meas.delta < l2) begin
          sel.three = 1'b1;
        end else if (meas.delta < l1) begin
          sel.two = 1'b1;
        end
      end
      CODE_TIME: begin
        // unsigned clock time, wraps past midnight into the last band
        if (meas.time_of_day >= limits.first &&
            meas.time_of_day < limits.second) begin
          sel.two = 1'b1;
        end else if (meas.time_of_day >= limits.second &&
                     (!four_on || meas.time_of_day < limits.third)) begin
          sel.three = 1'b1;
        end else if (four_on) begin
          sel.four = 1'b1;
        end else begin
          sel.three = 1'b1;
        end
      end
      CODE_VOLUME: begin
        sel.two   = (meas.inlet > meas.outlet) &&
                    (meas.inlet >= heat_cool_switch_threshold);
        sel.three = (meas.inlet < meas.outlet) &&
                    (meas.inlet <= heat_cool_switch_threshold);
      end
      CODE_PQ: begin
        sel.two   = meas.power > l1;
        sel.three = meas.flow > l2;
      end
      default: sel = '0;
    endcase
  end

  // ------------------------------------------------------------
  // accumulation
  // ------------------------------------------------------------
  logic [ACC_W-1:0] inc_ext;
  assign inc_ext = {{(ACC_W-INC_W){1'b0}}, incr};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      main_register <= ACC_RESET;
    end else if (incr_valid) begin
      main_register <= main_register + inc_ext;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tariff_accumulator_two   <= ACC_RESET;
      tariff_accumulator_three <= ACC_RESET;
      tariff_accumulator_four  <= ACC_RESET;
    end else if (incr_valid) begin
      if (sel.two) begin
        tariff_accumulator_two <= tariff_accumulator_two + inc_ext;
      end
      if (sel.three) begin
        tariff_accumulator_three <= tariff_accumulator_three + inc_ext;
      end
      if (sel.four) begin
        tariff_accumulator_four <= tariff_accumulator_four + inc_ext;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  main_always_a: assert property (incr_valid |=>
    main_register == $past(main_register) + $past(inc_ext))
    else $error("main register missed an increment");
  idle_hold_a: assert property (!incr_valid |=>
    $stable(tariff_accumulator_two) && $stable(tariff_accumulator_three)
    && $stable(tariff_accumulator_four))
    else $error("accumulator moved without increment");
  none_code_a: assert property ((tariff_type_code == CODE_NONE) |->
    sel == '0)
    else $error("tariff selected with no tariff code");
  four_off_a: assert property (!four_on |-> !sel.four)
    else $error("accumulator four used while disabled");
  power_low_a: assert property ((tariff_type_code == CODE_POWER &&
    meas.power <= l1) |-> sel == '0)
    else $error("power band low selected accumulator");
  power_top_a: assert property ((tariff_type_code == CODE_POWER &&
    four_on && meas.power > l3) |-> sel.four && !sel.two && !sel.three)
    else $error("power top band wrong");
  flow_mid_a: assert property ((tariff_type_code == CODE_FLOW &&
    meas.flow > l2 && meas.flow <= l3) |-> sel.three && !sel.four)
    else $error("flow band three wrong");
  volume_four_a: assert property ((tariff_type_code == CODE_VOLUME ||
    tariff_type_code == CODE_PQ) |-> !sel.four)
    else $error("accumulator four used in volume or pq");
  pq_both_a: assert property ((tariff_type_code == CODE_PQ &&
    meas.power > l1 && meas.flow > l2) |-> sel.two && sel.three)
    else $error("pq did not select both");
  power_mid_a: assert property ((tariff_type_code == CODE_POWER &&
    l1 < l2 && l2 < l3 && meas.power > l1 && meas.power <= l2) |->
    sel.two && !sel.three && !sel.four)
    else $error("power band two wrong");
  flow_low_a: assert property ((tariff_type_code == CODE_FLOW &&
    l1 < l2 && l2 < l3 && meas.flow <= l1) |-> sel == '0)
    else $error("flow band low selected accumulator");
  dt_top_a: assert property ((tariff_type_code == CODE_DT &&
    l3 < l2 && l2 < l1 && meas.delta >= l1) |-> sel == '0)
    else $error("difference above first limit selected accumulator");
  dt_low_a: assert property ((tariff_type_code == CODE_DT &&
    four_on && meas.delta < l3) |-> sel.four && !sel.two && !sel.three)
    else $error("difference low band wrong");
  inlet_top_a: assert property ((tariff_type_code == CODE_INLET &&
    four_on && meas.inlet > l3) |-> sel.four && !sel.two && !sel.three)
    else $error("inlet top band wrong");
  outlet_low_a: assert property (
    (tariff_type_code == CODE_OUTLET && l1 < l2 && l2 < l3 &&
    meas.outlet <= l1) |-> sel == '0)
    else $error("outlet band low selected accumulator");
  time_two_a: assert property ((tariff_type_code == CODE_TIME &&
    meas.time_of_day >= limits.first &&
    meas.time_of_day < limits.second) |->
    sel.two && !sel.three && !sel.four)
    else $error("time band two wrong");
  time_four_a: assert property ((tariff_type_code == CODE_TIME &&
    four_on && limits.first < limits.second &&
    limits.second < limits.third &&
    (meas.time_of_day >= limits.third ||
    meas.time_of_day < limits.first)) |-> sel.four && !sel.three)
    else $error("time band four wrong");
  one_code_a: assert property ((tariff_type_code != CODE_PQ) |->
    $onehot0({sel.two, sel.three, sel.four}))
    else $error("more than one accumulator outside pq");
  vol_equal_a: assert property ((tariff_type_code == CODE_VOLUME &&
    meas.inlet == meas.outlet) |-> sel == '0)
    else $error("volume split with equal temperatures");

  // ------------------------------------------------------------
  // accumulator checks
  // ------------------------------------------------------------
  // these watch the sums, so a broken adder shows even if sel is right
  two_add_a: assert property ((incr_valid && sel.two) |=>
    tariff_accumulator_two ==
    $past(tariff_accumulator_two) + $past(inc_ext))
    else $error("accumulator two missed an increment");
  two_skip_a: assert property ((incr_valid && !sel.two) |=>
    $stable(tariff_accumulator_two))
    else $error("accumulator two moved when not selected");
  three_add_a: assert property ((incr_valid && sel.three) |=>
    tariff_accumulator_three ==
    $past(tariff_accumulator_three) + $past(inc_ext))
    else $error("accumulator three missed an increment");
  three_skip_a: assert property ((incr_valid && !sel.three) |=>
    $stable(tariff_accumulator_three))
    else $error("accumulator three moved when not selected");
  four_add_a: assert property ((incr_valid && sel.four) |=>
    tariff_accumulator_four ==
    $past(tariff_accumulator_four) + $past(inc_ext))
    else $error("accumulator four missed an increment");
  four_skip_a: assert property ((incr_valid && !sel.four) |=>
    $stable(tariff_accumulator_four))
    else $error("accumulator four moved when not selected");

  power_cov_c: cover property (tariff_type_code == CODE_POWER && sel.four
    && incr_valid);
  pq_cov_c: cover property (sel.two && sel.three && incr_valid);
  dt_cov_c: cover property (tariff_type_code == CODE_DT && sel.two);
  time_cov_c: cover property (tariff_type_code == CODE_TIME && sel.four);
  vol_cov_c: cover property (tariff_type_code == CODE_VOLUME && sel.three
    && incr_valid);
endmodule : tas_selector

// [verif/tas_core_model.sv]
`timescale 1ns/100ps
module tas_core_model
  import tas_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             go,
  input  wire logic [INC_W-1:0] amount,
  output logic                  incr_valid,
  output logic [INC_W-1:0]      incr
);
  // ------------------------------------------------------------
  // integration pulses
  // ------------------------------------------------------------
  // idle increment is scrambled so a stale value cannot pass
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      incr_valid <= 1'b0;
      incr       <= '0;
    end else begin
      incr_valid <= go;
      incr       <= go ? amount : ~incr;
    end
  end
endmodule : tas_core_model

// [verif/tas_selector_bench.sv]
`timescale 1ns/100ps
module tas_selector_bench
  import tas_pkg::*;
;
  localparam logic [15:0] Z = 16'h0000;
  localparam logic [15:0] L1 = 16'h000a;
  localparam logic [15:0] L2 = 16'h0014;
  localparam logic [15:0] L3 = 16'h001e;
  localparam logic [15:0] AMT = 16'hffff;
  localparam logic [15:0] H8 = 16'h0008;
  localparam logic [15:0] H16 = 16'h0010;
  localparam logic [15:0] H23 = 16'h0017;
  logic           mclk, nrst, go, incr_valid;
  logic [7:0]     code;
  tas_limits_type lim;
  tas_meas_type   meas;
  logic [15:0]    incr;
  logic [15:0]    thr;
  logic [31:0]    mreg, a2, a3, a4, em, e2, e3, e4;
  int             num_errors, comparisons, cycles;

  tas_selector dut (.mclk(mclk), .nrst(nrst), .tariff_type_code(code),
    .limits(lim), .meas(meas), .heat_cool_switch_threshold(thr),
    .incr_valid(incr_valid), .incr(incr), .main_register(mreg),
    .tariff_accumulator_two(a2), .tariff_accumulator_three(a3),
    .tariff_accumulator_four(a4));
  tas_core_model core (.mclk(mclk), .nrst(nrst), .go(go), .amount(AMT),
    .incr_valid(incr_valid), .incr(incr));

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task chk_all();
    chk(mreg, em);
    chk(a2, e2);
    chk(a3, e3);
    chk(a4, e4);
  endtask : chk_all

  // one integration; idle cycle after it must not count again
  task step(input logic [7:0] c, input logic [15:0] a, b, d, v, w,
            input logic [2:0] e);
    @(posedge mclk);
    code <= c;
    lim  <= '{a, b, d};
    meas <= '{v, w, v, w, v, v};
    go   <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    em = em + 32'(AMT);
    if (e[2]) e2 = e2 + 32'(AMT);
    if (e[1]) e3 = e3 + 32'(AMT);
    if (e[0]) e4 = e4 + 32'(AMT);
    chk_all();
    $display("step code %h done", c);
  endtask : step

  task complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // clock, timeout, sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // about 130 cycles expected; generous ceiling
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    {nrst, go, code, lim, meas} = '0;
    {em, e2, e3, e4} = '0;
    {num_errors, comparisons, cycles} = '0;
    thr = 16'h0032;
    repeat (4) @(posedge mclk);
    chk_all();
    nrst <= 1'b1;
    step(CODE_NONE, L1, L2, L3, 16'h0064, 16'h0064, 3'b000);
    step(8'h16, L1, L2, L3, 16'h0064, 16'h0064, 3'b000);
    step(CODE_POWER, L1, L2, L3, L1, Z, 3'b000);
    step(CODE_POWER, L1, L2, L3, 16'h000b, Z, 3'b100);
    step(CODE_POWER, L1, L2, L3, L3, Z, 3'b010);
    step(CODE_POWER, L1, L2, L3, 16'h001f, Z, 3'b001);
    step(CODE_POWER, L1, L2, Z, 16'h001f, Z, 3'b010);
    step(CODE_POWER, L1, L2, L3, Z, 16'h0064, 3'b000);
    step(CODE_FLOW, L1, L2, L3, Z, L2, 3'b100);
    step(CODE_FLOW, L1, L2, L3, Z, 16'h0015, 3'b010);
    step(CODE_FLOW, L1, L2, L3, Z, 16'h001f, 3'b001);
    step(CODE_DT, L3, L2, L1, L3, Z, 3'b000);
    step(CODE_DT, L3, L2, L1, 16'h001d, Z, 3'b100);
    step(CODE_DT, L3, L2, L1, 16'h0009, Z, 3'b001);
    step(CODE_INLET, L1, L2, L3, 16'h0015, Z, 3'b010);
    step(CODE_INLET, L1, L2, L3, 16'hfff6, L3, 3'b000);
    step(CODE_OUTLET, L1, L2, L3, 16'h0064, 16'h000b, 3'b100);
    step(CODE_TIME, H8, H16, H23, H8, Z, 3'b100);
    step(CODE_TIME, H8, H16, H23, 16'h0003, Z, 3'b001);
    step(CODE_TIME, H8, H16, H23, H16, Z, 3'b010);
    step(CODE_TIME, H8, H16, H23, H23, Z, 3'b001);
    step(CODE_TIME, H8, H16, Z, 16'h0014, Z, 3'b010);
    step(CODE_VOLUME, L1, L2, L3, 16'h003c, 16'h0028, 3'b100);
    step(CODE_VOLUME, L1, L2, L3, 16'h0028, 16'h003c, 3'b010);
    step(CODE_VOLUME, L1, L2, L3, 16'h0028, L3, 3'b000);
    step(CODE_VOLUME, L1, L2, L3, 16'h003c, 16'h0046, 3'b000);
    @(posedge mclk);
    thr <= 16'h0046;
    step(CODE_VOLUME, L1, L2, L3, 16'h003c, 16'h0028, 3'b000);
    step(CODE_PQ, L1, L2, L3, 16'h000b, 16'h0015, 3'b110);
    step(CODE_PQ, L1, L2, L3, L1, 16'h0015, 3'b010);
    // mid-run reset must clear every accumulator
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    {em, e2, e3, e4} = '0;
    chk_all();
    @(posedge mclk);
    nrst <= 1'b1;
    step(CODE_POWER, L1, L2, L3, 16'h000b, Z, 3'b100);
    complete_run();
  end
endmodule : tas_selector_bench
